// ===== src/edd_pkg.sv
// Notes on behaviour
// RULE_01 - Fine steps span about 2 to 193 us
// RULE_02 - Separate rise/fall enables and counts, default 0x01
// RULE_03 - Each count adds one 750 ns step
// RULE_04 - Count of zero still gives about 2 us
// RULE_05 - Step select switches unit to 1 ms
// RULE_06 - Debounce: 100 ms falling, rising delay off
// RULE_07 - Rising-only: rise delayed, fall passes immediately
// RULE_08 - Falling-only: rise immediate, fall held off
// RULE_09 - Undelayed edges take the combinational path
// RULE_10 - Output-enable mux picks pass path or delay logic
// RULE_11 - Pass path is AND with inverted unused terms
// RULE_12 - Input returning early abandons the countdown
package edd_pkg;

    // Clock and delay timing
    localparam int CLOCK_NS = 20;
    localparam int OVERHEAD_NS = 2000;
    localparam int OVERHEAD_CYCLES = (OVERHEAD_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int FINE_STEP_NS = 750;
    localparam int FINE_STEP_CYCLES = (FINE_STEP_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int MS_STEP_NS = 1000000;
    localparam int MS_STEP_CYCLES = MS_STEP_NS / CLOCK_NS;

    // Configuration after reset
    localparam int COUNT_WIDTH = 8;
    localparam logic [7:0] COUNT_RESET = 8'h01;
    localparam logic RISE_ENABLE_RESET = 1'b1;
    localparam logic FALL_ENABLE_RESET = 1'b1;
    localparam logic MS_SELECT_RESET = 1'b0;

    // Widths of the internal counters
    localparam int OVERHEAD_WIDTH = 7;
    localparam int STEP_WIDTH = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OVERHEAD,
        ST_STEPS
    } edd_state_t;

endpackage

// ===== src/edd_step_tick.sv
`timescale 1ns/1ns
`default_nettype none
module edd_step_tick #(
    parameter int STEP_WIDTH = edd_pkg::STEP_WIDTH,
    parameter int FINE_CYCLES = edd_pkg::FINE_STEP_CYCLES,
    parameter int MS_CYCLES = edd_pkg::MS_STEP_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Control
    input wire logic i_restart,
    input wire logic i_millisecond_step_select,
    // Step pulse
    output logic o_tick
);

    generate
        if (FINE_CYCLES < 1 || MS_CYCLES < 1 || MS_CYCLES > (1 << STEP_WIDTH)
                || FINE_CYCLES > (1 << STEP_WIDTH)) begin : g_bad
            $error("edd_step_tick: step cycle count out of range");
        end
    endgenerate

    logic [STEP_WIDTH-1:0] count;
    logic [STEP_WIDTH-1:0] next_count;
    logic [STEP_WIDTH-1:0] last;

    // Period of one count step, fine or millisecond
    always_comb begin
        if (i_millisecond_step_select) begin // RULE_05
            last = STEP_WIDTH'(MS_CYCLES - 1);
        end else begin
            last = STEP_WIDTH'(FINE_CYCLES - 1); // RULE_03
        end
        if (i_restart || count == last) begin
            next_count = '0;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_tick = !i_restart && (count == last);

endmodule // edd_step_tick
`default_nettype wire

// ===== src/edd_delay.sv
`timescale 1ns/1ns
`default_nettype none
module edd_delay #(
    parameter int COUNT_WIDTH = edd_pkg::COUNT_WIDTH,
    parameter int MS_STEP_CYCLES = edd_pkg::MS_STEP_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Signal path
    input wire logic i_signal,
    output logic o_signal,
    // Configuration, taken on i_config_write
    input wire logic i_config_write,
    input wire logic i_rise_enable,
    input wire logic i_fall_enable,
    input wire logic i_millisecond_step_select,
    input wire logic [COUNT_WIDTH-1:0] i_rise_count,
    input wire logic [COUNT_WIDTH-1:0] i_fall_count,
    // Status
    output logic o_logic_cell_output_enable,
    output logic o_busy,
    output logic o_level,
    output logic [COUNT_WIDTH-1:0] o_remaining
);

    generate
        if (COUNT_WIDTH < 1 || COUNT_WIDTH > 16 || MS_STEP_CYCLES < 1) begin : g_bad
            $error("edd_delay: parameter out of range");
        end
    endgenerate

    // Configuration registers
    logic rise_en;
    logic fall_en;
    logic ms_select;
    logic [COUNT_WIDTH-1:0] rise_count;
    logic [COUNT_WIDTH-1:0] fall_count;
    logic next_rise_en;
    logic next_fall_en;
    logic next_ms_select;
    logic [COUNT_WIDTH-1:0] next_rise_count;
    logic [COUNT_WIDTH-1:0] next_fall_count;

    always_comb begin
        next_rise_en = rise_en;
        next_fall_en = fall_en;
        next_ms_select = ms_select;
        next_rise_count = rise_count;
        next_fall_count = fall_count;
        if (i_config_write) begin // RULE_02
            next_rise_en = i_rise_enable;
            next_fall_en = i_fall_enable;
            next_ms_select = i_millisecond_step_select;
            next_rise_count = i_rise_count;
            next_fall_count = i_fall_count;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rise_en <= edd_pkg::RISE_ENABLE_RESET;
            fall_en <= edd_pkg::FALL_ENABLE_RESET;
            ms_select <= edd_pkg::MS_SELECT_RESET;
            rise_count <= COUNT_WIDTH'(edd_pkg::COUNT_RESET);
            fall_count <= COUNT_WIDTH'(edd_pkg::COUNT_RESET);
        end else begin
            rise_en <= next_rise_en;
            fall_en <= next_fall_en;
            ms_select <= next_ms_select;
            rise_count <= next_rise_count;
            fall_count <= next_fall_count;
        end
    end

    // Delay sequencer state
    edd_pkg::edd_state_t state;
    edd_pkg::edd_state_t next_state;
    logic held;
    logic next_held;
    logic [edd_pkg::OVERHEAD_WIDTH-1:0] overhead;
    logic [edd_pkg::OVERHEAD_WIDTH-1:0] next_overhead;
    logic [COUNT_WIDTH-1:0] remaining;
    logic [COUNT_WIDTH-1:0] next_remaining;
    logic tick;
    logic edge_delayed;
    logic pass_path;
    logic sel_pass;

    // Pass-through cell: input ANDed with inverted, unused terms
    assign pass_path = i_signal & ~1'b0 & ~1'b0 & ~1'b0; // RULE_11

    // Edge leaving the held level is delayed if its enable is set
    assign edge_delayed = held ? fall_en : rise_en; // RULE_07 RULE_08

    // Mux: pass path when idle and the next edge is not delayed
    assign sel_pass = (state == edd_pkg::ST_IDLE) && !edge_delayed; // RULE_09 RULE_10

    edd_step_tick #(
        .STEP_WIDTH(edd_pkg::STEP_WIDTH),
        .FINE_CYCLES(edd_pkg::FINE_STEP_CYCLES),
        .MS_CYCLES(MS_STEP_CYCLES)
    ) u_step_tick (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_restart(state != edd_pkg::ST_STEPS),
        .i_millisecond_step_select(ms_select),
        .o_tick(tick)
    );

    always_comb begin
        next_state = state;
        next_held = held;
        next_overhead = overhead;
        next_remaining = remaining;
        case (state)
            edd_pkg::ST_IDLE: begin
                if (i_signal != held) begin
                    if (edge_delayed) begin
                        next_state = edd_pkg::ST_OVERHEAD;
                        next_overhead = edd_pkg::OVERHEAD_WIDTH'(edd_pkg::OVERHEAD_CYCLES - 1);
                    end else begin
                        next_held = i_signal; // RULE_09
                    end
                end
            end
            edd_pkg::ST_OVERHEAD: begin
                if (i_signal == held) begin
                    next_state = edd_pkg::ST_IDLE; // RULE_12
                end else if (overhead == '0) begin
                    next_state = edd_pkg::ST_STEPS; // RULE_04
                    next_remaining = held ? fall_count : rise_count;
                end else begin
                    next_overhead = overhead - 1'b1;
                end
            end
            edd_pkg::ST_STEPS: begin
                if (i_signal == held) begin
                    next_state = edd_pkg::ST_IDLE; // RULE_12
                end else if (remaining == '0) begin
                    next_state = edd_pkg::ST_IDLE;
                    next_held = ~held; // RULE_01
                end else if (tick) begin
                    next_remaining = remaining - 1'b1; // RULE_03
                end
            end
            default: begin
                next_state = edd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= edd_pkg::ST_IDLE;
            held <= 1'b0;
            overhead <= '0;
            remaining <= '0;
        end else begin
            state <= next_state;
            held <= next_held;
            overhead <= next_overhead;
            remaining <= next_remaining;
        end
    end

    assign o_signal = sel_pass ? pass_path : held; // RULE_10
    assign o_logic_cell_output_enable = sel_pass;
    assign o_busy = (state != edd_pkg::ST_IDLE);
    assign o_level = held;
    assign o_remaining = remaining;

    // Helper counters for the checks below
    logic [7:0] ovh_seen;
    logic [7:0] next_ovh_seen;
    logic [edd_pkg::STEP_WIDTH:0] gap;
    logic [edd_pkg::STEP_WIDTH:0] next_gap;

    always_comb begin
        next_ovh_seen = ovh_seen + 1'b1;
        next_gap = gap + 1'b1;
        if (state != edd_pkg::ST_OVERHEAD) begin
            next_ovh_seen = '0;
        end
        if (state != edd_pkg::ST_STEPS || tick) begin
            next_gap = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ovh_seen <= '0;
            gap <= '0;
        end else begin
            ovh_seen <= next_ovh_seen;
            gap <= next_gap;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking

    default disable iff (i_rst);

    sequence s_commit_point;
        state == edd_pkg::ST_STEPS && remaining == '0 && i_signal != held;
    endsequence

    sequence s_leave_overhead;
        state == edd_pkg::ST_OVERHEAD && overhead == '0 && i_signal != held;
    endsequence

    property p_config_default;
        $past(i_rst) && !i_rst |->
            rise_count == COUNT_WIDTH'(edd_pkg::COUNT_RESET)
            && fall_count == COUNT_WIDTH'(edd_pkg::COUNT_RESET);
    endproperty
    a_config_default: assert property (p_config_default) // RULE_02
        else $error("counts not at default after reset");

    property p_overhead_len;
        s_leave_overhead |-> ovh_seen == 8'(edd_pkg::OVERHEAD_CYCLES - 1);
    endproperty
    a_overhead_len: assert property (p_overhead_len) // RULE_04
        else $error("overhead phase has wrong length");

    property p_fine_step;
        state == edd_pkg::ST_STEPS && tick && !ms_select |->
            gap == (edd_pkg::STEP_WIDTH + 1)'(edd_pkg::FINE_STEP_CYCLES - 1);
    endproperty
    a_fine_step: assert property (p_fine_step) // RULE_03
        else $error("fine step period wrong");

    property p_ms_step;
        state == edd_pkg::ST_STEPS && tick && ms_select |->
            gap == (edd_pkg::STEP_WIDTH + 1)'(MS_STEP_CYCLES - 1);
    endproperty
    a_ms_step: assert property (p_ms_step) // RULE_05
        else $error("millisecond step period wrong");

    property p_commit;
        s_commit_point |=> state == edd_pkg::ST_IDLE && held != $past(held)
            && o_signal == held;
    endproperty
    a_commit: assert property (p_commit) // RULE_01
        else $error("delayed edge not committed");

    property p_rise_only_fall;
        state == edd_pkg::ST_IDLE && rise_en && !fall_en && held && !i_signal
            |-> !o_signal ##1 !held;
    endproperty
    a_rise_only_fall: assert property (p_rise_only_fall) // RULE_07
        else $error("falling edge not passed in rising-only mode");

    property p_fall_only_rise;
        state == edd_pkg::ST_IDLE && fall_en && !rise_en && !held && i_signal
            |-> o_signal ##1 held;
    endproperty
    a_fall_only_rise: assert property (p_fall_only_rise) // RULE_08
        else $error("rising edge not passed in falling-only mode");

    property p_delayed_holds;
        state == edd_pkg::ST_IDLE && edge_delayed && i_signal != held
            |-> o_signal == held ##1 state == edd_pkg::ST_OVERHEAD;
    endproperty
    a_delayed_holds: assert property (p_delayed_holds) // RULE_07
        else $error("delayed edge reached the output early");

    property p_pass_follows;
        state == edd_pkg::ST_IDLE && !edge_delayed |->
            o_logic_cell_output_enable && o_signal == i_signal;
    endproperty
    a_pass_follows: assert property (p_pass_follows) // RULE_09
        else $error("pass path not selected");

    property p_mux_seq;
        state != edd_pkg::ST_IDLE |-> !o_logic_cell_output_enable && o_signal == held;
    endproperty
    a_mux_seq: assert property (p_mux_seq) // RULE_10
        else $error("delay logic not driving the output");

    property p_and_path;
        o_logic_cell_output_enable |-> o_signal == i_signal;
    endproperty
    a_and_path: assert property (p_and_path) // RULE_11
        else $error("pass path alters the input");

    property p_glitch;
        state != edd_pkg::ST_IDLE && i_signal == held |=>
            state == edd_pkg::ST_IDLE && $stable(held);
    endproperty
    a_glitch: assert property (p_glitch) // RULE_12
        else $error("glitch not rejected");

    property p_rise_load;
        s_leave_overhead ##0 !held |=> state == edd_pkg::ST_STEPS
            && remaining == $past(rise_count);
    endproperty
    a_rise_load: assert property (p_rise_load) // RULE_02
        else $error("rising count not loaded");

    property p_fall_load;
        s_leave_overhead ##0 held |=> state == edd_pkg::ST_STEPS
            && remaining == $past(fall_count);
    endproperty
    a_fall_load: assert property (p_fall_load) // RULE_02
        else $error("falling count not loaded");

endmodule // edd_delay
`default_nettype wire

// ===== tb/edd_switch.sv
`timescale 1ns/1ns
`default_nettype none
// Mechanical contact: each move of the target bounces before it settles
module edd_switch #(
    parameter int BOUNCES = 3,
    parameter int GAP = 20
) (
    // Clock
    input wire logic i_clock,
    // Wanted contact level
    input wire logic i_target,
    // Contact line
    output logic o_contact
);
    int left = 0;
    int hold = 0;
    initial o_contact = 1'b1;
    always @(negedge i_clock) begin
        if (left > 0) begin
            if (hold > 1) begin
                hold = hold - 1;
            end else begin
                o_contact <= ~o_contact;
                left = left - 1;
                hold = GAP;
            end
        end else if (o_contact !== i_target) begin
            // Bounces of even count, so the contact ends at the target
            o_contact <= i_target;
            left = 2 * BOUNCES;
            hold = GAP;
        end
    end
endmodule // edd_switch
`default_nettype wire

// ===== tb/tb_edd_delay.sv
`timescale 1ns/1ns
`default_nettype none
module tb_edd_delay;
    localparam int MS = 50;
    localparam int FS = 38;
    localparam int OVH = 101;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic drv = 1'b0;
    logic use_sw = 1'b0;
    logic sw_target = 1'b1;
    logic wr = 1'b0;
    logic re = 1'b1;
    logic fe = 1'b1;
    logic ms = 1'b0;
    logic [7:0] rc = 8'h01;
    logic [7:0] fc = 8'h01;
    wire logic contact;
    wire logic sig;
    logic o_signal;
    logic oe;
    logic busy;
    logic level;
    logic [7:0] remaining;
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    logic b;

    assign sig = use_sw ? contact : drv;
    always #10 i_clock = ~i_clock;

    edd_switch sw (.i_clock(i_clock), .i_target(sw_target), .o_contact(contact));

    edd_delay #(.COUNT_WIDTH(8), .MS_STEP_CYCLES(MS)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_signal(sig), .o_signal(o_signal),
        .i_config_write(wr), .i_rise_enable(re), .i_fall_enable(fe),
        .i_millisecond_step_select(ms), .i_rise_count(rc), .i_fall_count(fc),
        .o_logic_cell_output_enable(oe), .o_busy(busy), .o_level(level),
        .o_remaining(remaining));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic r, input logic f, input logic m,
                       input logic [7:0] rcv, input logic [7:0] fcv);
        @(negedge i_clock);
        re = r;
        fe = f;
        ms = m;
        rc = rcv;
        fc = fcv;
        wr = 1'b1;
        @(negedge i_clock);
        wr = 1'b0;
    endtask

    // Cycles from the sampling edge to the output change, -1 if immediate
    task automatic lat(input logic lvl, output int cnt, output logic bz);
        @(negedge i_clock);
        drv = lvl;
        bz = 1'b0;
        #1;
        if (o_signal === lvl) begin
            cnt = -1;
        end else begin
            @(posedge i_clock);
            for (cnt = 0; cnt < 12000; cnt++) begin
                @(negedge i_clock);
                if (cnt == 50) bz = busy;
                if (o_signal === lvl) break;
            end
        end
    endtask

    task automatic t_reset();
        check(o_signal, 1'b0);
        check(busy, 1'b0);
        check(remaining, 8'h00);
        check(oe, 1'b0);
        lat(1'b1, n, b);
        check(n, OVH + FS);
        check(b, 1'b1);
        check(level, 1'b1);
        lat(1'b0, n, b);
        check(n, OVH + FS);
        $display("test reset done");
    endtask

    task automatic t_counts();
        cfg(1'b1, 1'b1, 1'b0, 8'h05, 8'h00);
        lat(1'b1, n, b);
        check(n, OVH + 5 * FS);
        lat(1'b0, n, b);
        check(n, OVH);
        cfg(1'b1, 1'b1, 1'b0, 8'hff, 8'h01);
        lat(1'b1, n, b);
        check(n, OVH + 255 * FS);
        lat(1'b0, n, b);
        check(n, OVH + FS);
        $display("test counts done");
    endtask

    task automatic t_modes();
        cfg(1'b1, 1'b0, 1'b0, 8'h03, 8'h09);
        lat(1'b1, n, b);
        check(n, OVH + 3 * FS);
        lat(1'b0, n, b);
        check(n, -1);
        check(oe, 1'b1);
        check(busy, 1'b0);
        cfg(1'b0, 1'b1, 1'b0, 8'h09, 8'h02);
        lat(1'b1, n, b);
        check(n, -1);
        check(o_signal, sig);
        lat(1'b0, n, b);
        check(n, OVH + 2 * FS);
        cfg(1'b0, 1'b0, 1'b0, 8'h09, 8'h09);
        lat(1'b1, n, b);
        check(n, -1);
        lat(1'b0, n, b);
        check(n, -1);
        $display("test modes done");
    endtask

    task automatic t_glitch();
        cfg(1'b1, 1'b1, 1'b0, 8'h04, 8'h04);
        @(negedge i_clock);
        drv = 1'b1;
        repeat (2) @(negedge i_clock);
        check(busy, 1'b1);
        repeat (30) @(negedge i_clock);
        drv = 1'b0;
        repeat (3) @(negedge i_clock);
        check(busy, 1'b0);
        repeat (300) @(negedge i_clock);
        check(o_signal, 1'b0);
        drv = 1'b1;
        repeat (110) @(negedge i_clock);
        check(remaining, 8'h04);
        check(level, 1'b0);
        drv = 1'b0;
        repeat (2) @(negedge i_clock);
        check(busy, 1'b0);
        check(o_signal, 1'b0);
        $display("test glitch done");
    endtask

    task automatic t_debounce();
        int last;
        logic prev;
        cfg(1'b0, 1'b1, 1'b1, 8'h01, 8'h64);
        use_sw = 1'b1;
        repeat (3) @(negedge i_clock);
        check(o_signal, 1'b1);
        sw_target <= 1'b0;
        prev = contact;
        last = 0;
        for (int i = 0; i < 6000; i++) begin
            @(negedge i_clock);
            #1;
            last = (contact !== prev) ? 0 : last + 1;
            prev = contact;
            if (o_signal === 1'b0) break;
        end
        check(last, OVH + 100 * MS + 1);
        $display("test debounce done");
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(60000 * 20);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 1'b0;
        #1;
        t_reset();
        t_counts();
        t_modes();
        t_glitch();
        t_debounce();
        end_of_test();
    end
endmodule // tb_edd_delay
`default_nettype wire
